// >>> core/ustx_pkg.sv
// package: constants, register layouts and types for the serial port
package ustx_pkg;
	// serial_control_one bit positions
	localparam int C1_EN    = 7;
	localparam int C1_DLEN  = 6;
	localparam int C1_PON   = 5;
	localparam int C1_PODD  = 4;
	localparam int C1_STOP2 = 3;
	localparam int C1_NINTH = 2;
	// serial_control_two bit positions
	localparam int C2_TRANSMIT_ENABLE  = 7;
	localparam int C2_RECEIVE_ENABLE  = 6;
	localparam int C2_SPEED = 5;
	localparam int C2_TRANSMIT_EMPTY_IRQ_ENABLE  = 4;
	localparam int C2_BRK   = 3;
	// serial_status bit positions
	localparam int ST_TRANSMIT_IDLE_FLAG = 3;
	localparam int ST_TXE   = 2;
	localparam int ST_RECEIVE_IDLE_FLAG = 1;
	localparam int ST_RXAV  = 0;
	// reset values: 8 data bits, no parity, one stop bit
	localparam logic [7:0] CTL1_RST = 8'h00;
	localparam logic [7:0] CTL2_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	// baud prescale in oversample ticks
	localparam logic [5:0] PRE_LOW  = 6'h3F;
	localparam logic [5:0] PRE_HIGH = 6'h0F;
	localparam logic [3:0] BRK_BITS = 4'hD;
	localparam logic [3:0] ONE4     = 4'h1;
	localparam logic [7:0] ONE8     = 8'h01;
	localparam logic [5:0] ZERO6    = 6'h00;

	typedef enum logic [1:0] {
		USTX_REG_CTL1,
		USTX_REG_CTL2,
		USTX_REG_BAUD,
		USTX_REG_DATA
	} ustx_reg_e;

	typedef enum logic [2:0] {
		USTX_IDLE,
		USTX_START,
		USTX_DATA,
		USTX_BREAK,
		USTX_STOP
	} ustx_state_e;

	// used by the port only: the bit sent at the last data slot
	function automatic logic ustx_last_bit(input logic [8:0] d,
		input logic dlen9, input logic pon, input logic podd);
		logic par;
		par = dlen9 ? ^d[7:0] : ^d[6:0];
		if (!pon)
			ustx_last_bit = dlen9 ? d[8] : d[7];
		else
			ustx_last_bit = par ^ podd;
	endfunction
endpackage

// >>> core/ustx_if.sv
// interface: the serial link between the port and its remote partner
interface ustx_if;
	logic tx_o;
	logic tx_oe;
	logic rx_i;
	logic peer_tx;
	modport port (output tx_o, output tx_oe, input rx_i);
	modport peer (input tx_o, input tx_oe, output peer_tx);
	assign rx_i = peer_tx;
endinterface

// >>> core/ustx_baud.sv
// baud divider: one-cycle bit enable pulses
module ustx_baud
	import ustx_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       run,
	input  wire logic       fast,
	input  wire logic [7:0] divisor,
	output logic            bit_tick
);
	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] cnt;
		logic       tick;
	} ustx_baud_s;
	ustx_baud_s st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (!run) begin
			nxt_st.pre = ZERO6;
			nxt_st.cnt = 8'h00;
		end else if (st_ff.pre != (fast ? PRE_HIGH : PRE_LOW)) begin
			nxt_st.pre = st_ff.pre + 6'h01;
		end else begin
			nxt_st.pre = ZERO6;
			if (st_ff.cnt >= divisor) begin
				nxt_st.cnt = 8'h00;
				nxt_st.tick = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + ONE8;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign bit_tick = st_ff.tick;
endmodule

// >>> core/ustx_port.sv
// device end: serial port control registers and transmitter
// How it works
// - NRZ frame, start, 8/9 data, stop_count_select
// - parity even/odd/none, reset 8N1
// - shared format and divider, LSB first
// - enabled pins drive; idle line high
// - master disable floats pins, empties buffer
// - master disable clears transmit/receive enables and break, sets idle flags
// - disable suspends; re-enable keeps configuration
// - separate length, parity, stop bits
// - parity or address takes last slot
// - ninth bit from control bit
// - shifter reloads only after stop bits
// - start needs enable, data, bit tick
// - transmit enable cleared aborts, floats pin
// - empty flag readable, gated interrupt
// - flags clear by status read then write
// - holding writes blocked while flag low
// - busy write held; idle write starts
// - idle flag set after stop_count_select or break
// - break is start plus 13n zeros
// - break repeats while held, then stop_count_select
// - break sends no transmit interrupt
// - baud is clock over 64(N+1) or 16(N+1)
module ustx_port
	import ustx_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [1:0] reg_sel,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       status_rd,
	output logic [7:0]      reg_rdata,
	output logic [7:0]      status,
	output logic            tx_irq,
	output logic            rx_level,
	ustx_if.port            link
);
	typedef struct packed {
		logic [7:0]  ctl1;
		logic [7:0]  ctl2;
		logic [7:0]  baud;
		logic [7:0]  hold;
		logic        hold_full;
		logic [8:0]  shift;
		ustx_state_e fsm;
		logic [3:0]  cnt;
		logic        stop2;
		logic        transmit_idle_flag;
		logic        txe;
		logic        armed;
		logic        sh_full;
		logic        brk;
		logic [7:0]  rdata;
		logic        rx_s;
	} ustx_port_s;
	ustx_port_s st_ff, nxt_st;
	logic bit_tick;
	logic en, transmit_enable, dlen9;

	assign en    = st_ff.ctl1[C1_EN];
	assign transmit_enable  = st_ff.ctl2[C2_TRANSMIT_ENABLE];
	assign dlen9 = st_ff.ctl1[C1_DLEN];

	ustx_baud u_baud (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.run      (en),
		.fast     (st_ff.ctl2[C2_SPEED]),
		.divisor  (st_ff.baud),
		.bit_tick (bit_tick)
	);

	always_comb begin
		logic last_bit;
		last_bit = 1'b0;
		nxt_st = st_ff;
		nxt_st.rx_s = link.rx_i;
		if (status_rd)
			nxt_st.armed = 1'b1;
		// holding register write
		if (reg_wr && reg_sel == USTX_REG_DATA && st_ff.txe) begin
			if (st_ff.armed) begin
				nxt_st.txe = 1'b0;
				nxt_st.transmit_idle_flag = 1'b0;
				nxt_st.armed = 1'b0;
			end
			nxt_st.hold = reg_wdata;
			nxt_st.hold_full = 1'b1;
		end
		// shifter engine
		case (st_ff.fsm)
			USTX_IDLE: begin
				// idle write goes straight to the shifter
				if (transmit_enable && nxt_st.hold_full && !st_ff.sh_full) begin
					nxt_st.shift = {st_ff.ctl1[C1_NINTH], nxt_st.hold};
					last_bit = ustx_last_bit(nxt_st.shift, dlen9,
						st_ff.ctl1[C1_PON], st_ff.ctl1[C1_PODD]);
					if (dlen9)
						nxt_st.shift[8] = last_bit;
					else
						nxt_st.shift[7] = last_bit;
					nxt_st.sh_full = 1'b1;
					nxt_st.hold_full = 1'b0;
					nxt_st.txe = 1'b1;
				end
				if (transmit_enable && st_ff.ctl2[C2_BRK] && bit_tick) begin
					nxt_st.fsm = USTX_START;
					nxt_st.brk = 1'b1;
				end else if (transmit_enable && st_ff.sh_full && bit_tick) begin
					nxt_st.fsm = USTX_START;
					nxt_st.brk = 1'b0;
					nxt_st.sh_full = 1'b0;
				end
				nxt_st.cnt = 4'h0;
			end
			USTX_START: if (bit_tick) begin
				nxt_st.cnt = 4'h0;
				nxt_st.fsm = st_ff.brk ? USTX_BREAK : USTX_DATA;
			end
			USTX_DATA: if (bit_tick) begin
				nxt_st.cnt = st_ff.cnt + ONE4;
				nxt_st.shift = {1'b0, st_ff.shift[8:1]};
				if (st_ff.cnt == (dlen9 ? 4'h8 : 4'h7)) begin
					nxt_st.fsm = USTX_STOP;
					nxt_st.cnt = 4'h0;
					nxt_st.stop2 = st_ff.ctl1[C1_STOP2];
				end
			end
			USTX_BREAK: if (bit_tick) begin
				nxt_st.cnt = st_ff.cnt + ONE4;
				if (st_ff.cnt == BRK_BITS - ONE4) begin
					nxt_st.cnt = 4'h0;
					if (!st_ff.ctl2[C2_BRK]) begin
						nxt_st.fsm = USTX_STOP;
						nxt_st.stop2 = st_ff.ctl1[C1_STOP2];
					end
				end
			end
			USTX_STOP: if (bit_tick) begin
				if (st_ff.stop2)
					nxt_st.stop2 = 1'b0;
				else begin
					nxt_st.fsm = USTX_IDLE;
					nxt_st.transmit_idle_flag = 1'b1;
				end
			end
			default: nxt_st.fsm = USTX_IDLE;
		endcase
		// register writes
		if (reg_wr) begin
			if (reg_sel == USTX_REG_CTL1)
				nxt_st.ctl1 = reg_wdata;
			else if (reg_sel == USTX_REG_CTL2)
				nxt_st.ctl2 = reg_wdata;
			else if (reg_sel == USTX_REG_BAUD)
				nxt_st.baud = reg_wdata;
		end
		// cleared enable stop_count_select the frame at this very edge
		if (!nxt_st.ctl2[C2_TRANSMIT_ENABLE]) begin
			nxt_st.fsm = USTX_IDLE;
			nxt_st.sh_full = 1'b0;
			if (st_ff.fsm != USTX_IDLE)
				nxt_st.transmit_idle_flag = 1'b1;
		end
		if (!nxt_st.ctl1[C1_EN]) begin
			nxt_st.ctl2[C2_TRANSMIT_ENABLE] = 1'b0;
			nxt_st.ctl2[C2_RECEIVE_ENABLE] = 1'b0;
			nxt_st.ctl2[C2_BRK] = 1'b0;
			nxt_st.hold_full = 1'b0;
			nxt_st.sh_full = 1'b0;
			nxt_st.fsm = USTX_IDLE;
			nxt_st.txe = 1'b1;
			nxt_st.transmit_idle_flag = 1'b1;
		end
		// read data latched from the addressed ctl1, ctl2 or baud register; the data register reads zero
		if (reg_rd) begin
			if (reg_sel == USTX_REG_CTL1)
				nxt_st.rdata = st_ff.ctl1;
			else if (reg_sel == USTX_REG_CTL2)
				nxt_st.rdata = st_ff.ctl2;
			else if (reg_sel == USTX_REG_BAUD)
				nxt_st.rdata = st_ff.baud;
			else
				nxt_st.rdata = 8'h00;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.ctl1 <= CTL1_RST;
			st_ff.ctl2 <= CTL2_RST;
			st_ff.baud <= BAUD_RST;
			st_ff.fsm <= USTX_IDLE;
			st_ff.txe <= 1'b1;
			st_ff.transmit_idle_flag <= 1'b1;
			st_ff.rx_s <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_comb begin
		status = 8'h00;
		status[ST_TRANSMIT_IDLE_FLAG] = st_ff.transmit_idle_flag;
		status[ST_TXE] = st_ff.txe;
		status[ST_RECEIVE_IDLE_FLAG] = 1'b1;
		status[ST_RXAV] = 1'b0;
	end
	assign reg_rdata = st_ff.rdata;
	// tx_irq only from the empty flag, never from break
	assign tx_irq = st_ff.txe && st_ff.ctl2[C2_TRANSMIT_EMPTY_IRQ_ENABLE];
	assign rx_level = (en && st_ff.ctl2[C2_RECEIVE_ENABLE]) ? st_ff.rx_s : 1'b1;
	assign link.tx_oe = en && transmit_enable;
	always_comb begin
		case (st_ff.fsm)
			USTX_START: link.tx_o = 1'b0;
			USTX_DATA: link.tx_o = st_ff.shift[0];
			USTX_BREAK: link.tx_o = 1'b0;
			default: link.tx_o = 1'b1;
		endcase
	end
	// data bit shift: after each data bit move next into bit 0
	// handled by shifting right with zero fill in the data state
endmodule

// >>> core/ustx_peer.sv
// far end: remote transceiver driving its own line, watching ours
module ustx_peer
	import ustx_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic drive_low,
	output logic      line_seen,
	output logic      line_driven,
	ustx_if.peer      link
);
	typedef struct packed {
		logic seen;
		logic driven;
		logic tx;
	} ustx_peer_s;
	ustx_peer_s st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.driven = link.tx_oe;
		nxt_st.seen = link.tx_oe ? link.tx_o : 1'b1;
		nxt_st.tx = !drive_low;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			st_ff <= 3'b101;
		else
			st_ff <= nxt_st;
	end
	assign line_seen = st_ff.seen;
	assign line_driven = st_ff.driven;
	assign link.peer_tx = st_ff.tx;
endmodule

// >>> testbench/ustx_asserts.sv
// checker: timing of the serial line between the two ends
module ustx_asserts #(
	parameter int BIT = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic tx_o,
	input wire logic tx_oe,
	input wire logic rx_i,
	input wire logic peer_tx
);
	logic [19:0] run_ff;
	logic        last_ff;
	logic        oe_ff;
	logic        sync_ff;
	logic        edge_ok;
	// run_ff: cycles the previous level was held
	assign edge_ok = sync_ff && oe_ff && tx_oe && tx_o != last_ff;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			run_ff  <= 20'h00000;
			last_ff <= 1'h1;
			oe_ff   <= 1'h0;
			sync_ff <= 1'h0;
		end else begin
			run_ff  <= (tx_oe && tx_o == last_ff) ? run_ff + 20'h1 : 20'h1;
			last_ff <= tx_o;
			oe_ff   <= tx_oe;
			sync_ff <= tx_oe && (sync_ff || (oe_ff && tx_o != last_ff));
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_idle_high: assert property ($rose(tx_oe) |-> tx_o)
		else $error("line low at enable");
	a_start_len: assert property ($fell(tx_o) && tx_oe |->
		(!tx_o || !tx_oe)[*8]) else $error("start bit short");
	a_edge_tick: assert property (edge_ok && tx_o |->
		run_ff % BIT == 0) else $error("low run off bit grid");
	a_low_run: assert property (edge_ok && tx_o |->
		run_ff <= 10 * BIT || run_ff >= 14 * BIT)
		else $error("low run length illegal");
	a_break_mult: assert property (edge_ok && tx_o &&
		run_ff >= 14 * BIT |-> (run_ff - BIT) % (13 * BIT) == 0)
		else $error("break not whole characters");
	a_stop_len: assert property (edge_ok && !tx_o |->
		run_ff >= BIT) else $error("stop bit short");
	a_bit_hold: assert property ($rose(tx_o) && $past(tx_oe) &&
		tx_oe |-> (tx_o || !tx_oe)[*8]) else $error("high bit short");
	a_rx_path: assert property (rx_i == peer_tx)
		else $error("receive pin not fed by peer");
	a_float_high: assert property (!tx_oe |-> tx_o)
		else $error("line low while floated");
	c_break: cover property (edge_ok && tx_o && run_ff >= 14 * BIT);
	c_frame: cover property (edge_ok && !tx_o);
	c_disable: cover property ($fell(tx_oe));
endmodule

// >>> testbench/tb_top.sv
// testbench: port and peer joined over the serial link
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ustx_pkg::*;
	logic       sys_clk = 1'h0;
	logic       rstn = 1'h0;
	logic       reg_wr = 1'h0;
	logic       reg_rd = 1'h0;
	logic [1:0] reg_sel = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       status_rd = 1'h0;
	logic       drive_low = 1'h0;
	logic [7:0] reg_rdata;
	logic [7:0] status;
	logic       tx_irq;
	logic       rx_level;
	logic       line_seen;
	logic       line_driven;
	logic [8:0] v;
	logic [8:0] q[$];
	int         error_cnt = 0;
	int         check_count = 0;
	int         nb = 8;
	bit         mon_on = 1'b1;
	bit         live = 1'b0;
	ustx_if lnk();
	ustx_port i_ustx_port(.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_sel,
		.reg_wdata, .status_rd, .reg_rdata, .status, .tx_irq, .rx_level,
		.link(lnk.port));
	ustx_peer i_ustx_peer(.sys_clk, .rstn, .drive_low, .line_seen,
		.line_driven, .link(lnk.peer));
	ustx_asserts i_ustx_asserts(.sys_clk, .rstn, .tx_o(lnk.tx_o),
		.tx_oe(lnk.tx_oe), .rx_i(lnk.rx_i), .peer_tx(lnk.peer_tx));
	always #12.5 sys_clk = ~sys_clk;
	task automatic end_sim();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		cyc(1);
		reg_sel = s;
		reg_wdata = d;
		reg_wr = 1'h1;
		cyc(1);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [1:0] s, input logic [8:0] e);
		cyc(1);
		reg_sel = s;
		reg_rd = 1'h1;
		cyc(1);
		reg_rd = 1'h0;
		cyc(1);
		chk({1'h0, reg_rdata}, e);
	endtask
	task automatic send(input logic [7:0] d);
		cyc(1);
		status_rd = 1'h1;
		cyc(1);
		status_rd = 1'h0;
		wr(2'h3, d);
	endtask
	task automatic get(input logic [8:0] e);
		for (int k = 0; k < 800 && q.size() == 0; k++) cyc(1);
		if (q.size() == 0) begin
			chk(9'h1FF, 9'h000);
			end_sim();
		end
		chk(q.pop_front(), e);
	endtask
	// waits n cycles, gives up once the line is floated
	task automatic wt(input int n);
		for (int k = 0; k < n && live; k++) begin
			@(posedge sys_clk);
			live = live && lnk.tx_oe;
		end
	endtask
	// frame decoder: samples mid-bit, 16 cycles a bit
	initial forever begin
		@(negedge lnk.tx_o);
		live = mon_on && lnk.tx_oe;
		wt(8);
		v = 9'h000;
		for (int i = 0; i < nb && live; i++) begin
			wt(16);
			v[i] = lnk.tx_o;
		end
		wt(16);
		if (live) begin
			chk({8'h00, lnk.tx_o}, 9'h001);
			q.push_back(v);
		end
	end
	task automatic fmt(input logic [7:0] c, input int n,
		input logic [7:0] d, input logic [8:0] e);
		cyc(16);
		wr(2'h0, c);
		nb = n;
		send(d);
		get(e);
	endtask
	task automatic t_formats();
		wr(2'h0, 8'h80);
		wr(2'h2, 8'h00);
		wr(2'h1, 8'hA0);
		fmt(8'h80, 8, 8'hA5, 9'h0A5);
		fmt(8'hA0, 8, 8'h13, 9'h093);
		fmt(8'hC4, 9, 8'h3C, 9'h13C);
		fmt(8'hF0, 9, 8'h0F, 9'h10F);
		fmt(8'hE8, 9, 8'h0F, 9'h00F);
	endtask
	task automatic t_queue();
		cyc(48);
		wr(2'h0, 8'h80);
		wr(2'h1, 8'hB0);
		nb = 8;
		send(8'h11);
		chk({1'h0, status}, 9'h006);
		send(8'h22);
		chk({1'h0, status}, 9'h002);
		chk({8'h00, tx_irq}, 9'h000);
		send(8'h33);
		get(9'h011);
		get(9'h022);
		cyc(200);
		chk(9'(q.size()), 9'h000);
		chk({1'h0, status}, 9'h00E);
	endtask
	task automatic t_break();
		int n;
		mon_on = 1'b0;
		wr(2'h1, 8'hA8);
		send(8'h00);
		for (n = 0; n < 600 && lnk.tx_o; n++) cyc(1);
		if (lnk.tx_o) begin
			chk(9'h1FF, 9'h000);
			end_sim();
		end
		cyc(40);
		wr(2'h1, 8'hA0);
		for (n = 42; n < 900 && !lnk.tx_o; n++) cyc(1);
		chk(9'(n), 9'h0E0);
		cyc(400);
		mon_on = 1'b1;
	endtask
	task automatic t_disable();
		send(8'h55);
		cyc(60);
		wr(2'h0, 8'h00);
		chk({8'h00, lnk.tx_oe}, 9'h000);
		chk({1'h0, status}, 9'h00E);
		rd(2'h1, 9'h020);
		wr(2'h0, 8'h80);
		wr(2'h1, 8'hA0);
		send(8'hC3);
		get(9'h0C3);
	endtask
	task automatic t_link();
		wr(2'h1, 8'hE0);
		drive_low = 1'h1;
		cyc(3);
		chk({8'h00, rx_level}, 9'h000);
		chk({7'h00, line_driven, line_seen}, 9'h003);
		drive_low = 1'h0;
		cyc(3);
		chk({8'h00, rx_level}, 9'h001);
		wr(2'h0, 8'h00);
		drive_low = 1'h1;
		cyc(3);
		chk({8'h00, rx_level}, 9'h001);
		chk({7'h00, line_driven, line_seen}, 9'h001);
		drive_low = 1'h0;
	endtask
	initial begin
		cyc(16);
		rstn = 1'h1;
		cyc(1);
		chk({1'h0, status}, 9'h00E);
		rd(2'h0, 9'h000);
		t_formats();
		t_queue();
		t_break();
		t_disable();
		t_link();
		end_sim();
	end
endmodule
